/* spp_defines.vh */
// Constants for the six-bit port with alternate functions.
// Assumes inclusion by bare name from the port design files.
`ifndef SPP_DEFINES_VH
`define SPP_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define SPP_ADDR_LATCH 32'hFFFFF40A
`define SPP_ADDR_DIR 32'hFFFFF42A
`define SPP_ADDR_MODE 32'hFFFFF44A
`define SPP_ADDR_FSEL 32'hFFFFF46A
`define SPP_ADDR_FSEL_EXP 32'hFFFFF70A
`define SPP_ADDR_PULLUP 32'hFFFFFC4A

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define SPP_IMPL_MASK 8'h3F
`define SPP_RST_LATCH 8'h00
`define SPP_RST_DIR 8'hFF
`define SPP_RST_MODE 8'h00
`define SPP_RST_FSEL 8'h00
`define SPP_RST_FSEL_EXP 8'h00
`define SPP_RST_PULLUP 8'h00
`define SPP_PIN_DBG_DIN 2
`define SPP_PIN_DBG_DOUT 3
`define SPP_PIN_DBG_CLK 4
`define SPP_PIN_DBG_MS 5

`endif

/* spp_sync.v */
// Two-stage synchroniser for a vector of pin levels.
// Assumes the inputs are asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module spp_sync #(
    parameter WIDTH = 6
) (
    input wire ref_clk,
    input wire rst,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // First stage feeds only the second
    always @(posedge ref_clk) begin
        if (rst) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule // spp_sync
`default_nettype wire

/* spp_port.v */
// Six-bit general purpose port with direction, latch, read-back and alternate functions.
// Assumes a simple internal bus with one-cycle strobes and a debug enable from the debug block.
`timescale 1ns/1ps
`default_nettype none
`include "spp_defines.vh"
module spp_port (
    input wire ref_clk,
    input wire rst,
    // Internal bus
    input wire [31:0] bus_addr,
    input wire bus_wr,
    input wire bus_rd,
    input wire bus_bit_access,
    input wire [2:0] bus_bit_sel,
    input wire [7:0] bus_wdata,
    output reg [7:0] bus_rdata,
    output reg bus_rvalid,
    // Pins
    input wire [5:0] pin_in,
    output reg [5:0] pin_out,
    output reg [5:0] pin_oe,
    output reg [5:0] pin_pullup_en,
    // Alternate-function peripherals
    output reg [5:0] key_return_input,
    output reg [3:0] timer_capture_input,
    input wire [3:0] timer_compare_output,
    // Debug function
    input wire debug_mode_enable_bit,
    output reg debug_data_in,
    input wire debug_data_out,
    output reg debug_clock,
    output reg debug_mode_select,
    output reg debug_reset_pulldown_en
);
    localparam [1:0] SEL_TIMER_IN = 2'b01;
    localparam [1:0] SEL_TIMER_OUT = 2'b10;
    // Register numbers after address decode
    localparam [2:0] REG_NONE = 3'h0;
    localparam [2:0] REG_LATCH = 3'h1;
    localparam [2:0] REG_DIR = 3'h2;
    localparam [2:0] REG_MODE = 3'h3;
    localparam [2:0] REG_FSEL = 3'h4;
    localparam [2:0] REG_FSEL_EXP = 3'h5;
    localparam [2:0] REG_PULLUP = 3'h6;

    reg [7:0] latch_r;
    reg [7:0] dir_r;
    reg [7:0] mode_r;
    reg [7:0] fsel_r;
    reg [7:0] fsel_exp_r;
    reg [7:0] pullup_r;
    reg dbg_en_r;
    reg [7:0] rd_nxt;
    reg [5:0] out_nxt;
    reg [5:0] oe_nxt;
    reg [5:0] kr_nxt;
    reg [3:0] tin_nxt;
    wire [5:0] pin_sync;
    wire [2:0] reg_sel;
    integer i;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Byte or single-bit merge into implemented bits
    function [7:0] wr_merge;
        input [7:0] old;
        input [7:0] wdata;
        input bit_access;
        input [2:0] sel;
        reg [7:0] m;
        begin
            m = bit_access ? (8'h01 << sel) : 8'hFF;
            wr_merge = ((old & ~m) | (wdata & m)) & `SPP_IMPL_MASK;
        end
    endfunction

    // Whole-address decode shared by write and read paths
    function [2:0] reg_decode;
        input [31:0] addr;
        begin
            case (addr)
                `SPP_ADDR_LATCH: reg_decode = REG_LATCH;
                `SPP_ADDR_DIR: reg_decode = REG_DIR;
                `SPP_ADDR_MODE: reg_decode = REG_MODE;
                `SPP_ADDR_FSEL: reg_decode = REG_FSEL;
                `SPP_ADDR_FSEL_EXP: reg_decode = REG_FSEL_EXP;
                `SPP_ADDR_PULLUP: reg_decode = REG_PULLUP;
                default: reg_decode = REG_NONE;
            endcase
        end
    endfunction

    // Decoded register of the current access
    assign reg_sel = reg_decode(bus_addr);

    // Pin synchroniser
    spp_sync #(
        .WIDTH(6)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // Writes by address; unmapped addresses ignored
    always @(posedge ref_clk) begin
        if (rst) begin
            latch_r <= `SPP_RST_LATCH;
            dir_r <= `SPP_RST_DIR & `SPP_IMPL_MASK;
            mode_r <= `SPP_RST_MODE;
            fsel_r <= `SPP_RST_FSEL;
            fsel_exp_r <= `SPP_RST_FSEL_EXP;
            pullup_r <= `SPP_RST_PULLUP;
        end else if (bus_wr) begin
            case (reg_sel)
                REG_LATCH: latch_r <= wr_merge(latch_r, bus_wdata, bus_bit_access, bus_bit_sel);
                REG_DIR: dir_r <= wr_merge(dir_r, bus_wdata, bus_bit_access, bus_bit_sel);
                REG_MODE: mode_r <= wr_merge(mode_r, bus_wdata, bus_bit_access, bus_bit_sel);
                REG_FSEL: fsel_r <= wr_merge(fsel_r, bus_wdata, bus_bit_access, bus_bit_sel);
                REG_FSEL_EXP: fsel_exp_r <= wr_merge(fsel_exp_r, bus_wdata, bus_bit_access, bus_bit_sel);
                REG_PULLUP: pullup_r <= wr_merge(pullup_r, bus_wdata, bus_bit_access, bus_bit_sel);
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    // Read mux; data register mixes pin and latch per direction
    always @* begin
        case (reg_sel)
            REG_LATCH: rd_nxt = {2'b00, (dir_r[5:0] & pin_sync) | (~dir_r[5:0] & latch_r[5:0])};
            REG_DIR: rd_nxt = dir_r;
            REG_MODE: rd_nxt = mode_r;
            REG_FSEL: rd_nxt = fsel_r;
            REG_FSEL_EXP: rd_nxt = fsel_exp_r;
            REG_PULLUP: rd_nxt = pullup_r;
            default: rd_nxt = 8'h00;
        endcase
    end

    // Registered read data, one cycle after the strobe
    always @(posedge ref_clk) begin
        if (rst) begin
            bus_rdata <= 8'h00;
            bus_rvalid <= 1'b0;
        end else begin
            bus_rvalid <= bus_rd;
            if (bus_rd) begin
                bus_rdata <= rd_nxt;
            end
        end
    end

    // ----------------------------------------
    // Pin function steering
    // ----------------------------------------
    // Per-pin choice of port, alternate and debug function
    always @* begin
        out_nxt = 6'h00;
        oe_nxt = 6'h00;
        kr_nxt = 6'h00;
        tin_nxt = 4'h0;
        for (i = 0; i < 6; i = i + 1) begin
            if (!mode_r[i]) begin
                out_nxt[i] = latch_r[i];
                oe_nxt[i] = ~dir_r[i];
            end else if (i < 4) begin
                case ({fsel_exp_r[i], fsel_r[i]})
                    SEL_TIMER_IN: begin
                        kr_nxt[i] = pin_sync[i];
                        tin_nxt[i] = pin_sync[i];
                    end
                    SEL_TIMER_OUT: begin
                        out_nxt[i] = timer_compare_output[i];
                        oe_nxt[i] = 1'b1;
                    end
                    default: ; // Prohibited: pin left undriven
                endcase
            end else if (fsel_r[i]) begin
                kr_nxt[i] = pin_sync[i];
            end
        end
        // Debug function overrides pins 2 to 5
        if (dbg_en_r) begin
            out_nxt[`SPP_PIN_DBG_DIN] = 1'b0;
            oe_nxt[`SPP_PIN_DBG_DIN] = 1'b0;
            out_nxt[`SPP_PIN_DBG_DOUT] = debug_data_out;
            oe_nxt[`SPP_PIN_DBG_DOUT] = 1'b1;
            out_nxt[`SPP_PIN_DBG_CLK] = 1'b0;
            oe_nxt[`SPP_PIN_DBG_CLK] = 1'b0;
            out_nxt[`SPP_PIN_DBG_MS] = 1'b0;
            oe_nxt[`SPP_PIN_DBG_MS] = 1'b0;
        end
    end

    // Registered pin and peripheral outputs
    always @(posedge ref_clk) begin
        if (rst) begin
            dbg_en_r <= 1'b1;
            pin_out <= 6'h00;
            pin_oe <= 6'h00;
            pin_pullup_en <= 6'h00;
            key_return_input <= 6'h00;
            timer_capture_input <= 4'h0;
            debug_data_in <= 1'b0;
            debug_clock <= 1'b0;
            debug_mode_select <= 1'b0;
            debug_reset_pulldown_en <= 1'b1;
        end else begin
            dbg_en_r <= debug_mode_enable_bit;
            pin_out <= out_nxt;
            pin_oe <= oe_nxt;
            pin_pullup_en <= pullup_r[5:0] & ~oe_nxt;
            key_return_input <= kr_nxt;
            timer_capture_input <= tin_nxt;
            debug_data_in <= dbg_en_r & pin_sync[`SPP_PIN_DBG_DIN];
            debug_clock <= dbg_en_r & pin_sync[`SPP_PIN_DBG_CLK];
            debug_mode_select <= dbg_en_r & pin_sync[`SPP_PIN_DBG_MS];
            debug_reset_pulldown_en <= debug_mode_enable_bit;
        end
    end
endmodule // spp_port
`default_nettype wire

/* spp_port_properties.sv */
// Port timing checker on the top-level ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module spp_port_properties (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_rvalid,
    input wire logic [5:0] pin_oe,
    input wire logic [5:0] pin_pullup_en,
    input wire logic debug_mode_enable_bit,
    input wire logic debug_data_in,
    input wire logic debug_reset_pulldown_en
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Read answer timing and content
    a_read_answered: assert property (bus_rd |=> bus_rvalid) else $error("read not answered");
    a_answer_cause: assert property (bus_rvalid |-> $past(bus_rd)) else $error("answer without read");
    a_top_zero: assert property (bus_rvalid |-> bus_rdata[7:6] == 2'h0) else $error("bits 7:6 set");
    a_rdata_holds: assert property (!bus_rvalid && !$past(rst) |-> $stable(bus_rdata)) else $error("data moved");
    // Pin, pull and debug relations
    a_pullup_undriven: assert property ((pin_pullup_en & pin_oe) == 6'h00) else $error("pull-up on driven pin");
    a_pulldown_copy:
        assert property (!$past(rst) |-> debug_reset_pulldown_en == $past(debug_mode_enable_bit))
        else $error("pull-down wrong");
    a_debug_quiet:
        assert property (!$past(rst, 2) && !$past(debug_mode_enable_bit, 2) && !$past(debug_mode_enable_bit)
        |-> !debug_data_in) else $error("debug input live");
    a_reset_quiet:
        assert property ($past(rst) |-> pin_oe == 6'h00 && !bus_rvalid && debug_reset_pulldown_en)
        else $error("outputs after reset");
endmodule // spp_port_properties
bind spp_port spp_port_properties u_props (.ref_clk, .rst, .bus_rd, .bus_rdata, .bus_rvalid, .pin_oe, .pin_pullup_en,
    .debug_mode_enable_bit, .debug_data_in, .debug_reset_pulldown_en);
`default_nettype wire

/* spp_pin_model.sv */
// Pin-side model: the device drive wins, else the outside level.
// Assumes the outside always drives every pin.
`timescale 1ns/1ps
`default_nettype none
module spp_pin_model (
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    input wire logic [5:0] ext_val,
    output logic [5:0] pin_in
);
    // Resolved pin level fed back to the device
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule // spp_pin_model
`default_nettype wire

/* test_spp_port.sv */
// Bench for the six-bit port: registers, pins, alternate and debug paths.
// Assumes the pin model outside and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "spp_defines.vh"
module test_spp_port;
    logic ref_clk = 1'h0, rst = 1'h1, bus_wr = 1'h0, bus_rd = 1'h0, bus_bit_access = 1'h0, bus_rvalid;
    logic debug_mode_enable_bit = 1'h1, debug_data_out = 1'h1, debug_data_in, debug_clock, debug_mode_select;
    logic debug_reset_pulldown_en;
    logic [31:0] bus_addr = 32'h0;
    logic [2:0] bus_bit_sel = 3'h0;
    logic [7:0] bus_wdata = 8'h00, bus_rdata, v, l, d;
    logic [5:0] pin_in, pin_out, pin_oe, pin_pullup_en, key_return_input, ext_val = 6'h00;
    logic [3:0] timer_capture_input, timer_compare_output = 4'h0;
    wire [3:0] dbg = {debug_data_in, debug_clock, debug_mode_select, debug_reset_pulldown_en};
    int failures = 0, checked = 0;
    spp_port dut (.ref_clk, .rst, .bus_addr, .bus_wr, .bus_rd, .bus_bit_access, .bus_bit_sel, .bus_wdata, .bus_rdata,
        .bus_rvalid, .pin_in, .pin_out, .pin_oe, .pin_pullup_en, .key_return_input, .timer_capture_input,
        .timer_compare_output, .debug_mode_enable_bit, .debug_data_in, .debug_data_out, .debug_clock,
        .debug_mode_select, .debug_reset_pulldown_en);
    spp_pin_model pins (.pin_out, .pin_oe, .ext_val, .pin_in);
    // Clock and hang limit
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        failures++;
        end_of_test();
    end
    // Compare and bus helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: check %0d got %h expected %h", $time, checked, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] w, input logic b = 1'h0, input logic [2:0] s = 3'h0);
        @(posedge ref_clk);
        {bus_wr, bus_addr, bus_wdata, bus_bit_access, bus_bit_sel} <= {1'h1, a, w, b, s};
        @(posedge ref_clk);
        bus_wr <= 1'h0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        {bus_rd, bus_addr, bus_bit_access} <= {1'h1, a, 1'h0};
        @(posedge ref_clk);
        bus_rd <= 1'h0;
        #1;
        chk({bus_rvalid, bus_rdata}, {1'h1, e});
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Latch after a byte or single-bit write
    function automatic logic [7:0] exp_latch(input logic [7:0] o, n, input logic b, input logic [2:0] s);
        return (b ? (o & ~(8'h01 << s)) | (n & (8'h01 << s)) : n) & 8'h3F;
    endfunction
    task automatic end_of_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        void'($urandom(6));
        repeat (6) @(posedge ref_clk);
        rst <= 1'h0;
        debug_mode_enable_bit <= 1'h0;
        rd(`SPP_ADDR_DIR, 8'h3F);
        rd(`SPP_ADDR_MODE, 8'h00);
        rd(32'h0, 8'h00);
        wr(`SPP_ADDR_DIR, 8'h00);
        rd(`SPP_ADDR_LATCH, 8'h00);
        $display("test reset done");
        l = 8'h00;
        for (int i = 0; i < 16; i++) begin
            v = 8'($urandom);
            @(posedge ref_clk);
            ext_val <= v[7:2];
            wr(`SPP_ADDR_DIR, v);
            wr(`SPP_ADDR_LATCH, ~v, i[3], i[2:0]);
            d = v & 8'h3F;
            l = exp_latch(l, ~v, i[3], i[2:0]);
            settle(1);
            chk({pin_oe, pin_out & pin_oe}, {~d[5:0], l[5:0] & ~d[5:0]});
            rd(`SPP_ADDR_LATCH, (d & {2'h0, v[7:2]}) | (~d & l));
        end
        $display("test data done");
        wr(`SPP_ADDR_DIR, 8'hFF);
        v = 8'($urandom);
        wr(`SPP_ADDR_PULLUP, v);
        rd(`SPP_ADDR_PULLUP, v & 8'h3F);
        chk(pin_pullup_en, v & 8'h3F);
        $display("test pull-up done");
        v = 8'($urandom);
        @(posedge ref_clk);
        ext_val <= v[5:0];
        timer_compare_output <= v[7:4];
        wr(`SPP_ADDR_FSEL, 8'h3F);
        wr(`SPP_ADDR_MODE, 8'hFF);
        settle(3);
        chk({key_return_input, timer_capture_input, pin_oe}, {v[5:0], v[3:0], 6'h00});
        wr(`SPP_ADDR_FSEL_EXP, 8'h0F);
        wr(`SPP_ADDR_FSEL, 8'h30);
        settle(2);
        chk({key_return_input, pin_oe, pin_out[3:0]}, {v[5:4], 4'h0, 6'h0F, v[7:4]});
        wr(`SPP_ADDR_FSEL, 8'h0F);
        settle(3);
        chk({key_return_input, timer_capture_input, pin_oe}, 16'h0000);
        wr(32'h0, 8'hFF);
        rd(`SPP_ADDR_MODE, 8'h3F);
        rd(`SPP_ADDR_FSEL, 8'h0F);
        rd(`SPP_ADDR_FSEL_EXP, 8'h0F);
        $display("test alternate done");
        @(posedge ref_clk);
        debug_mode_enable_bit <= 1'h1;
        settle(4);
        chk({dbg, pin_oe[3], pin_out[3]}, {v[2], v[4], v[5], 3'h7});
        @(posedge ref_clk);
        debug_mode_enable_bit <= 1'h0;
        settle(3);
        chk(dbg, 4'h0);
        $display("test debug done");
        end_of_test();
    end
endmodule // test_spp_port
`default_nettype wire
